// File: rtl/sar_adc_conversion_interface.sv
`timescale 1ns/100ps
module sar_adc_conversion_interface (
    // Clock, reset and clock enable
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Host control pins
    input  wire logic        conversion_start_n,
    input  wire logic        upper_byte_output_enable_n,
    input  wire logic        lower_nibble_output_enable_n,
    // Result pins, three-state
    output logic [11:0]      result_out,
    output logic [11:0]      result_oe_n,
    // Status pin
    output logic             conversion_done_flag,
    // Conversion clock pin, two-way
    input  wire logic        conv_clk_in,
    output logic             conv_clk_out,
    output logic             conv_clk_oe_n,
    input  wire logic        ext_clock_select,
    // Analog core
    input  wire logic        comparator_high,
    output logic             track_enable,
    output logic [11:0]      trial_code
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    sar_pkg::sync_in_t raw_in;                        // Pins as they arrive
    sar_pkg::sync_in_t sync1;                         // First stage, read only by sync2
    sar_pkg::sync_in_t sync2;                         // Safe to use
    logic              ext_clk_d;                     // Delayed copy for edge detect
    sar_pkg::sync_in_t next_sync1;
    sar_pkg::sync_in_t next_sync2;
    logic              next_ext_clk_d;

    assign raw_in = '{start_n:    conversion_start_n,
                      upper_oe_n: upper_byte_output_enable_n,
                      lower_oe_n: lower_nibble_output_enable_n,
                      ext_clk:    conv_clk_in,
                      ext_sel:    ext_clock_select,
                      comp:       comparator_high};

    // Two flops on every asynchronous input
    always_comb begin
        next_sync1     = raw_in;
        next_sync2     = sync1;
        next_ext_clk_d = sync2.ext_clk;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1     <= sar_pkg::SYNC_RESET;
            sync2     <= sar_pkg::SYNC_RESET;
            ext_clk_d <= 1'b0;
        end else if (ce) begin
            sync1     <= next_sync1;
            sync2     <= next_sync2;
            ext_clk_d <= next_ext_clk_d;
        end
    end

    // ---------------------------------------------------------------
    // Internal oscillator and step selection
    // ---------------------------------------------------------------
    sar_pkg::seq_state_t state;                       // Sequencer state
    logic [5:0]          div_cnt;                     // Half-period counter
    logic                int_clk;                     // Internal conversion clock
    logic [5:0]          next_div_cnt;
    logic                next_int_clk;
    logic                osc_run;                     // Oscillator allowed to toggle
    logic                int_rise;                    // Internal clock rising this cycle
    logic                step;                        // One conversion clock rising edge

    // In internal mode parking stops our own oscillator once its high half is over; an outside clock cannot be stopped
    assign osc_run  = sync2.ext_sel || (state == sar_pkg::seq_run) || int_clk;
    assign int_rise = osc_run && (div_cnt == sar_pkg::DIV_LAST) && !int_clk;
    // Every period boundary is a rising edge of whichever clock is in use
    assign step     = sync2.ext_sel ? (sync2.ext_clk && !ext_clk_d) : int_rise;

    // In internal mode the divider holds its phase while parked, so the low part of period 2 stretches
    always_comb begin
        next_div_cnt = div_cnt;
        next_int_clk = int_clk;
        if (osc_run) begin
            if (div_cnt == sar_pkg::DIV_LAST) begin
                next_div_cnt = sar_pkg::DIV_RESET;
                next_int_clk = ~int_clk;
            end else begin
                next_div_cnt = div_cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= sar_pkg::DIV_RESET;
            int_clk <= 1'b0;
        end else if (ce) begin
            div_cnt <= next_div_cnt;
            int_clk <= next_int_clk;
        end
    end

    // Clock pin is driven only when the internal oscillator is in use
    assign conv_clk_out  = int_clk;
    assign conv_clk_oe_n = sync2.ext_sel;

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    logic [3:0]            period;                    // Current period, 1 to 15
    logic [11:0]           sar;                       // Trial word being resolved
    logic                  armed;                     // Start seen in its legal window
    logic                  done;                      // Conversion done flag
    logic                  track;                     // Input tracking
    sar_pkg::seq_state_t   next_state;
    logic [3:0]            next_period;
    logic [11:0]           next_sar;
    logic                  next_armed;
    logic                  next_done;
    logic                  next_track;
    logic [11:0]           resolved;                  // Sar with this period's bit decided
    logic [3:0]            bit_idx;                   // Bit under test this period
    logic [3:0]            next_bit_idx;              // Bit to test next period
    logic                  start_low;                 // Host asks for a conversion
    logic                  push_valid;                // Finished word offered to the buffer
    logic                  push_ready;                // Buffer has room
    sar_pkg::result_word_t push_data;

    assign start_low = !sync2.start_n;

    always_comb begin
        next_state   = state;
        next_period  = period;
        next_sar     = sar;
        next_armed   = armed;
        next_done    = done;
        push_valid   = 1'b0;
        bit_idx      = sar_pkg::PERIOD_LAST - period;
        next_bit_idx = sar_pkg::PERIOD_LAST - (period + 4'h1);
        resolved     = sar;
        // Periods 4..15 each settle one bit, msb first
        if (period >= sar_pkg::PERIOD_BIT_MSB) begin
            resolved[bit_idx] = sync2.comp;
        end
        push_data = '{code: resolved};
        unique case (state)
            sar_pkg::seq_run: begin
                // Start counts during period 1 or at the step that ends period 15, never earlier in the cycle
                if (period == sar_pkg::PERIOD_FIRST && start_low) begin
                    next_armed = 1'b1;
                end
                if (step) begin
                    if (period == sar_pkg::PERIOD_LAST) begin
                        push_valid = 1'b1;
                        // A full buffer holds the cycle in period 15 until room appears
                        if (push_ready) begin
                            next_period = sar_pkg::PERIOD_FIRST;
                            next_done   = 1'b1;
                            next_sar    = sar_pkg::RESULT_RESET;
                            next_armed  = start_low;
                        end
                    end else if (period == sar_pkg::PERIOD_FIRST) begin
                        next_period = sar_pkg::PERIOD_HALT;
                        if (armed || start_low) begin
                            next_done  = 1'b0;
                            next_armed = 1'b0;
                        end else begin
                            next_state = sar_pkg::seq_halt;
                        end
                    end else begin
                        next_period = period + 4'h1;
                        next_sar    = resolved;
                        if (next_period >= sar_pkg::PERIOD_BIT_MSB) begin
                            next_sar[next_bit_idx] = 1'b1;
                        end
                    end
                end
            end
            sar_pkg::seq_halt: begin
                // Parked: input keeps tracking and the flag keeps its value
                if (start_low) begin
                    next_state = sar_pkg::seq_run;
                    next_done  = 1'b0;
                    next_armed = 1'b0;
                end
            end
        endcase
        next_track = (next_period <= sar_pkg::PERIOD_TRACK_END);
    end

    // After reset the cycle waits parked in period 2 with no result flagged
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state  <= sar_pkg::seq_halt;
            period <= sar_pkg::PERIOD_HALT;
            sar    <= sar_pkg::RESULT_RESET;
            armed  <= 1'b0;
            done   <= 1'b0;
            track  <= 1'b1;
        end else if (ce) begin
            state  <= next_state;
            period <= next_period;
            sar    <= next_sar;
            armed  <= next_armed;
            done   <= next_done;
            track  <= next_track;
        end
    end

    assign conversion_done_flag = done;
    assign track_enable         = track;
    assign trial_code           = sar;

    // ---------------------------------------------------------------
    // Result buffer and output latch
    // ---------------------------------------------------------------
    logic                  drain_valid;
    logic                  drain_ready;
    sar_pkg::result_word_t drain_data;
    logic [11:0]           result_q;                  // Word on the drivers
    logic [11:0]           next_result_q;

    result_buffer u_result_buffer (
        .mclk      (mclk),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_data)
    );

    // Never change the drivers while the host has either field enabled
    assign drain_ready = sync2.upper_oe_n && sync2.lower_oe_n;

    // Old word stays until a new one is transferred
    always_comb begin
        next_result_q = result_q;
        if (drain_valid && drain_ready) begin
            next_result_q = drain_data.code;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            result_q <= sar_pkg::RESULT_RESET;
        end else if (ce) begin
            result_q <= next_result_q;
        end
    end

    assign result_out = result_q;
    // Each field drives only while its own enable is held low
    assign result_oe_n[11:sar_pkg::UPPER_FIELD_LSB]  = {sar_pkg::UPPER_FIELD_WIDTH{sync2.upper_oe_n}};
    assign result_oe_n[sar_pkg::UPPER_FIELD_LSB-1:0] = {sar_pkg::LOWER_FIELD_WIDTH{sync2.lower_oe_n}};

endmodule // sar_adc_conversion_interface

// File: rtl/sar_pkg.sv
package sar_pkg;

    // Result word geometry
    localparam int          RESULT_WIDTH      = 12;
    localparam int          UPPER_FIELD_LSB   = 4;           // Upper byte starts at bit 4
    localparam int          UPPER_FIELD_WIDTH = 8;
    localparam int          LOWER_FIELD_WIDTH = 4;

    // Conversion cycle periods, counted 1 to 15
    localparam logic [3:0]  PERIOD_FIRST      = 4'h1;        // First tracking period
    localparam logic [3:0]  PERIOD_HALT       = 4'h2;        // Period in which the cycle may park
    localparam logic [3:0]  PERIOD_TRACK_END  = 4'h3;        // Last tracking period
    localparam logic [3:0]  PERIOD_BIT_MSB    = 4'h4;        // Period that tests the msb
    localparam logic [3:0]  PERIOD_LAST       = 4'hf;        // Period that tests the lsb

    // Internal oscillator derived from mclk
    localparam int          MCLK_FREQ_KHZ     = 20000;       // 20 MHz system clock
    localparam int          INT_CLK_FREQ_KHZ  = 300;         // Nominal internal conversion clock
    localparam int          INT_CLK_HALF_CYC  = MCLK_FREQ_KHZ / (2 * INT_CLK_FREQ_KHZ);
    localparam int          DIV_WIDTH         = 6;
    localparam logic [5:0]  DIV_LAST          = 6'(INT_CLK_HALF_CYC - 1);
    localparam logic [5:0]  DIV_RESET         = 6'h00;

    // Reset values and buffer depth
    localparam logic [11:0] RESULT_RESET      = 12'h000;
    localparam logic [1:0]  COUNT_RESET       = 2'h0;
    localparam logic [1:0]  BUFFER_DEPTH      = 2'h2;

    // Result word as it travels through the buffer
    typedef struct packed {
        logic [11:0] code;                                   // Unsigned binary, msb at bit 11
    } result_word_t;

    // Everything that arrives from outside mclk's domain
    typedef struct packed {
        logic start_n;                                       // Start request, active low
        logic upper_oe_n;                                    // Upper byte enable, active low
        logic lower_oe_n;                                    // Lower nibble enable, active low
        logic ext_clk;                                       // External conversion clock
        logic ext_sel;                                       // High selects the external clock
        logic comp;                                          // Comparator says input above trial
    } sync_in_t;

    localparam sync_in_t    SYNC_RESET        = '{start_n: 1'b1, upper_oe_n: 1'b1, lower_oe_n: 1'b1,
                                                  ext_clk: 1'b0, ext_sel: 1'b0, comp: 1'b0};

    // Sequencer states
    typedef enum logic [0:0] {
        seq_run  = 1'b0,                                     // Periods advance on each step, except period 15 while the buffer is full
        seq_halt = 1'b1                                      // Parked in period 2 awaiting start
    } seq_state_t;

endpackage

// File: rtl/result_buffer.sv
`timescale 1ns/100ps
module result_buffer (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    input  wire logic                  ce,
    // Filling side
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire sar_pkg::result_word_t in_data,
    // Draining side
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output sar_pkg::result_word_t      out_data
);

    sar_pkg::result_word_t mem [2];                  // Two entries in flip-flops
    sar_pkg::result_word_t next_mem [2];
    logic                  wr_ptr;                   // Next slot to write
    logic                  rd_ptr;                   // Oldest slot
    logic [1:0]            count;                    // Words held
    logic                  next_wr_ptr;
    logic                  next_rd_ptr;
    logic [1:0]            next_count;
    logic                  push;
    logic                  pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (count != sar_pkg::BUFFER_DEPTH);
    assign out_valid = (count != sar_pkg::COUNT_RESET);
    assign out_data  = mem[rd_ptr];

    // Pointer and storage update
    always_comb begin
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr      = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        // Simultaneous push and pop leaves the count alone
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    // Registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mem[0] <= '{code: sar_pkg::RESULT_RESET};
            mem[1] <= '{code: sar_pkg::RESULT_RESET};
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= sar_pkg::COUNT_RESET;
        end else if (ce) begin
            mem    <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

endmodule // result_buffer

// File: tb/analog_source_model.sv
`timescale 1ns/100ps
module analog_source_model (
    // Level at the analog input, as the code it should give
    input  wire logic [11:0] input_code,
    // Analog core as seen from the sequencer
    input  wire logic        track_enable,
    input  wire logic [11:0] trial_code,
    output logic             comparator_high
);
    logic [11:0] held_code;   // Level frozen when tracking ends

    // Follow the input while tracking, then hold it like the sampling capacitor
    always_latch begin
        if (track_enable) begin
            held_code <= input_code;
        end
    end

    // High keeps the trial bit; top of range gives all ones, bottom gives zero
    assign comparator_high = (held_code >= trial_code);
endmodule // analog_source_model

// File: tb/conversion_checks_properties.sv
`timescale 1ns/100ps
module conversion_checks_properties (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Host pins
    input wire logic        upper_byte_output_enable_n,
    input wire logic        lower_nibble_output_enable_n,
    input wire logic        ext_clock_select,
    // Device outputs
    input wire logic [11:0] result_out,
    input wire logic [11:0] result_oe_n,
    input wire logic        conversion_done_flag,
    input wire logic        conv_clk_oe_n,
    input wire logic        track_enable,
    input wire logic [11:0] trial_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Enables pass two sync flops before they reach the drivers
    oe_upper_a: assert property (result_oe_n[11:4] == {8{$past(upper_byte_output_enable_n, 2)}})
        else $error("upper byte drivers not following their enable");
    oe_lower_a: assert property (result_oe_n[3:0] == {4{$past(lower_nibble_output_enable_n, 2)}})
        else $error("lower nibble drivers not following their enable");
    // Word never swapped under a reader
    read_gap_a: assert property ($changed(result_out) |-> $past(result_oe_n) == 12'hfff)
        else $error("result changed while being read");
    // Period 4 tries the msb alone
    msb_trial_a: assert property ($fell(track_enable) |-> trial_code == 12'h800 && !conversion_done_flag)
        else $error("wrong trial word at end of tracking");
    done_fall_a: assert property ($fell(conversion_done_flag) |-> track_enable)
        else $error("done fell outside the tracking periods");
    done_rise_a: assert property ($rose(conversion_done_flag) |-> ##[0:2] track_enable)
        else $error("done rose without a new cycle starting");
    track_done_a: assert property ($rose(track_enable) |-> ##[0:2] conversion_done_flag)
        else $error("cycle restarted without done");
    // Clock pin is left to the outside in external mode
    clk_ext_a: assert property (ext_clock_select [*4] |-> conv_clk_oe_n)
        else $error("clock pin driven in external mode");
    clk_int_a: assert property (!ext_clock_select [*4] |-> !conv_clk_oe_n)
        else $error("clock pin not driven in internal mode");

    done_seen_c: cover property ($rose(conversion_done_flag));
    hold_seen_c: cover property ($fell(track_enable));
    load_seen_c: cover property ($changed(result_out));
endmodule // conversion_checks_properties

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
    // Host and pin drive
    logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, start_n = 1'b1, up_n = 1'b1, lo_n = 1'b1;
    logic ext_clk = 1'b0, ext_sel = 1'b0, ext_run = 1'b0;
    logic [11:0] target = 12'h000;            // Analog level as a code
    // Device outputs
    logic [11:0] result_out, result_oe_n, trial_code;
    logic        done, conv_clk_out, conv_clk_oe_n, comp, track;
    int          n_errors = 0, cmp_count = 0, ext_div = 0;

    always #25 mclk = ~mclk;

    // External conversion clock, only runs while a frame is wanted
    always @(posedge mclk) begin
        if (ext_run && ext_div == 19) begin
            ext_div <= 0;
            ext_clk <= ~ext_clk;
        end else if (ext_run) begin
            ext_div <= ext_div + 1;
        end
    end

    sar_adc_conversion_interface sar_adc_conversion_interface_inst (
        .mclk(mclk), .nrst(nrst), .ce(ce), .conversion_start_n(start_n),
        .upper_byte_output_enable_n(up_n), .lower_nibble_output_enable_n(lo_n),
        .result_out(result_out), .result_oe_n(result_oe_n), .conversion_done_flag(done),
        .conv_clk_in(ext_clk), .conv_clk_out(conv_clk_out), .conv_clk_oe_n(conv_clk_oe_n),
        .ext_clock_select(ext_sel), .comparator_high(comp), .track_enable(track), .trial_code(trial_code));

    analog_source_model analog_source_model_inst (
        .input_code(target), .track_enable(track), .trial_code(trial_code), .comparator_high(comp));

    task automatic finish_test;
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait for the done flag, sampled mid-cycle where it is settled
    task automatic wait_level(input logic lvl, input int bound, output int n);
        n = 0;
        while (done !== lvl && n < bound) begin
            @(negedge mclk);
            n++;
        end
        if (done !== lvl) begin
            n_errors++;
            finish_test();
        end
    endtask

    task automatic pulse_start;
        @(posedge mclk) start_n <= 1'b0;
        repeat (4) @(posedge mclk);
        start_n <= 1'b1;
    endtask

    // One shot, with a start pulse in mid-cycle that must be ignored
    task automatic convert(input logic [11:0] code);
        int n;
        target = code;
        pulse_start();
        repeat (300) @(posedge mclk);
        check("done mid cycle", {11'h0, done}, 12'h000);
        pulse_start();
        wait_level(1'b1, 3000, n);
        repeat (4) @(posedge mclk);
        check("result", result_out, code);
    endtask

    // Host reads the whole word, then lets the pins float again
    task automatic read_word(input logic [11:0] code);
        @(posedge mclk) up_n <= 1'b0;
        lo_n <= 1'b0;
        repeat (3) @(posedge mclk);
        check("drivers on", result_oe_n, 12'h000);
        check("word read", result_out, code);
        up_n <= 1'b1;
        lo_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    // Without a new start the oscillator parks low in period 2 and done stays high
    task automatic parked_check;
        // Period 1 still runs its 66 mclk, then the high half of period 2 ends
        repeat (110) @(posedge mclk);
        repeat (3) begin
            repeat (20) @(posedge mclk);
            check("parked clock", {11'h0, conv_clk_out}, 12'h000);
        end
        check("parked done", {11'h0, done}, 12'h001);
    endtask

    task automatic split_enables(input logic [11:0] code);
        @(posedge mclk) up_n <= 1'b0;
        repeat (3) @(posedge mclk);
        check("upper only", result_oe_n, 12'h00f);
        up_n <= 1'b1;
        lo_n <= 1'b0;
        repeat (3) @(posedge mclk);
        check("lower only", result_oe_n, 12'hff0);
        check("word held", result_out, code);
        lo_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    // Start held low: back to back cycles of fifteen 66-mclk periods
    task automatic held_start;
        int n1, n2;
        target = 12'h0f0;
        @(posedge mclk) start_n <= 1'b0;
        wait_level(1'b0, 200, n1);
        wait_level(1'b1, 2000, n1);
        // Second cycle is tracking now, so it must pick up the new level
        target = 12'h3c3;
        wait_level(1'b0, 200, n1);
        wait_level(1'b1, 2000, n2);
        check("cycle length", {11'h0, (n1 + n2 >= 988 && n1 + n2 <= 992)}, 12'h001);
        // The word reaches the drivers one mclk after the flag
        repeat (2) @(posedge mclk);
        check("free run result", result_out, 12'h3c3);
        @(posedge mclk) start_n <= 1'b1;
        wait_level(1'b0, 200, n1);
        wait_level(1'b1, 2000, n1);
    endtask

    // External clock: no edge, no progress
    task automatic ext_clock_run;
        int n;
        @(posedge mclk) ext_sel <= 1'b1;
        target = 12'h5a6;
        repeat (6) @(posedge mclk);
        check("clock pin released", {11'h0, conv_clk_oe_n}, 12'h001);
        pulse_start();
        repeat (300) @(posedge mclk);
        // No conversion clock edge: period 1 and the old flag still stand
        check("stalled done", {11'h0, done}, 12'h001);
        ext_run <= 1'b1;
        wait_level(1'b0, 200, n);
        wait_level(1'b1, 3000, n);
        ext_run <= 1'b0;
        read_word(12'h5a6);
        @(posedge mclk) ext_sel <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        logic [11:0] codes [4];
        codes = '{12'ha5c, 12'hfff, 12'h000, 12'h801};
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        check("reset drivers", result_oe_n, 12'hfff);
        check("reset done", {11'h0, done}, 12'h000);
        check("reset word", result_out, 12'h000);
        foreach (codes[i]) begin
            convert(codes[i]);
            parked_check();
            read_word(codes[i]);
        end
        split_enables(12'h801);
        held_start();
        ext_clock_run();
        finish_test();
    end
endmodule // tb

bind sar_adc_conversion_interface conversion_checks_properties conversion_checks_properties_inst (
    .mclk(mclk), .nrst(nrst), .upper_byte_output_enable_n(upper_byte_output_enable_n),
    .lower_nibble_output_enable_n(lower_nibble_output_enable_n), .ext_clock_select(ext_clock_select),
    .result_out(result_out), .result_oe_n(result_oe_n), .conversion_done_flag(conversion_done_flag),
    .conv_clk_oe_n(conv_clk_oe_n), .track_enable(track_enable), .trial_code(trial_code));
